//--- design/iep_pkg.sv
// shared constants and types for the two-wire eeprom page access link
package iep_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and link timing
    localparam int CLK_PERIOD_NS    = 25;
    localparam int SCL_PERIOD_NS    = 200;
    // quarter of a link bit period, rounded down, at least one cycle
    localparam int SCL_QTR_CYC      = (SCL_PERIOD_NS / (4 * CLK_PERIOD_NS)) < 1 ? 1
                                      : SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int QTR_W            = 4;
    // self-timed nonvolatile write time, longest figure, rounded down
    localparam int NV_WRITE_TIME_US = 10000;
    localparam int NV_WRITE_CYC     = (NV_WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int NV_TMR_W         = 20;

    ////////////////////////////////////////////////////////////////////////
    // address byte and memory layout
    localparam logic [3:0] DEV_ADDR_HI  = 4'h5;   // arbitrary value
    localparam logic       RW_READ      = 1'b1;
    localparam int         MEM_AW       = 8;
    localparam int         MEM_DEPTH    = 256;
    localparam int         PAGE_BYTES   = 2;
    localparam logic [7:0] MEM_RESET    = 8'hff;
    localparam logic [3:0] BIT_LAST     = 4'h7;
    localparam logic [3:0] BIT_ACK      = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // byte-level commands of the bus master end
    typedef enum logic [2:0] {
        CMD_START,
        CMD_WRITE,
        CMD_READ_ACK,
        CMD_READ_NACK,
        CMD_STOP
    } iep_cmd_e;

endpackage: iep_pkg

//--- design/iep_link_if.sv
// two-wire link between the bus master end and the memory device end
`timescale 1ns/100ps
interface iep_link_if;
    logic scl;
    logic mstSdaOut;
    logic mstSdaOe;
    logic devSdaOut;
    logic devSdaOe;
    logic sda;

    // open-drain data line, released high when nobody pulls it
    assign sda = (mstSdaOe ? mstSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);

    modport dev (
        input  scl,
        input  sda,
        output devSdaOut,
        output devSdaOe
    );

    modport mst (
        output scl,
        output mstSdaOut,
        output mstSdaOe,
        input  sda
    );
endinterface: iep_link_if

//--- design/iep_dev.sv
// memory device end: two-wire target with paged eeprom write and busy window
//
// Functional notes
// R1: location byte after address loads counter
// R2: master sends address, location, data, stop
// R3: at most one two-byte page per write
// R4: counter advances after each written byte
// R5: pages are two bytes, start on even
// R6: extra write bytes wrap within current page
// R7: master page write: even location, two bytes; the bench also writes at 07 and ff and writes 0, 1, 3 or 4 bytes
// R8: stop after data starts self-timed page write
// R9: no address acknowledge while write runs
// R10: master polls address or waits write time
// R11: whole page rewritten on every write
// R12: unwritten page bytes keep their contents
// R13: read starts at counter, no location byte
// R14: master single read ends with nack, stop
// R15: master sets location by dummy write first
// R16: master ack asks device for next byte
// R17: master nacks last byte then stops
// R18: seven address bits high, direction bit low
// R19: three select inputs set low address bits
// R20: wrong address ignored until next start
// R21: counter increments after each byte read
// R22: location-only write starts no nv cycle
`timescale 1ns/100ps
module iep_dev #(
    parameter int NV_WRITE_CYCLES = iep_pkg::NV_WRITE_CYC
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic srst,
    // link
    iep_link_if.dev   link,
    // address select straps
    input  wire logic addrSelectBit0,
    input  wire logic addrSelectBit1,
    input  wire logic addrSelectBit2,
    // status
    output logic      nvBusy,
    output logic      pageCommit
);
    import iep_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_LOC,
        ST_WDAT,
        ST_RDAT,
        ST_IGN
    } iep_dst_e;

    iep_dst_e              state_r;
    logic [1:0]            sclSync_r;
    logic [1:0]            sdaSync_r;
    logic [2:0]            selSync1_r;
    logic [2:0]            selSync2_r;
    logic                  sclPrev_r;
    logic                  sdaPrev_r;
    logic [3:0]            bitCnt_r;
    logic [7:0]            shift_r;
    logic [MEM_AW-1:0]     addrCnt_r;
    logic [7:0]            pageBuf_r [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pageDirty_r;
    logic                  sdaOe_r;
    logic [NV_TMR_W-1:0]   nvTmr_r;
    logic                  pageCommit_r;
    logic [7:0]            mem_r [MEM_DEPTH];

    logic                  sclS;
    logic                  sdaS;
    logic                  sclRise;
    logic                  sclFall;
    logic                  startDet;
    logic                  stopDet;
    logic                  addrMatch;
    logic                  commitNow;
    logic [7:0]            memRd;
    logic [MEM_AW-1:0]     pageNext;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, two flops before any logic
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sclSync_r  <= 2'h3;
            sdaSync_r  <= 2'h3;
            selSync1_r <= 3'h0;
            selSync2_r <= 3'h0;
            sclPrev_r  <= 1'b1;
            sdaPrev_r  <= 1'b1;
        end else begin
            sclSync_r  <= {sclSync_r[0], link.scl};
            sdaSync_r  <= {sdaSync_r[0], link.sda};
            selSync1_r <= {addrSelectBit2, addrSelectBit1, addrSelectBit0};
            selSync2_r <= selSync1_r;
            sclPrev_r  <= sclSync_r[1];
            sdaPrev_r  <= sdaSync_r[1];
        end
    end

    // edge and bus condition detection on synchronised levels
    assign sclS     = sclSync_r[1];
    assign sdaS     = sdaSync_r[1];
    assign sclRise  = sclS & ~sclPrev_r;
    assign sclFall  = ~sclS & sclPrev_r;
    assign startDet = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
    assign stopDet  = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

    // address compare: fixed high bits, straps low, direction ignored
    assign addrMatch = (shift_r[7:1] == {DEV_ADDR_HI, selSync2_r}); // R18 R19

    // read data at the counter, next address inside the same page
    assign memRd     = mem_r[addrCnt_r];                           // R13
    assign pageNext  = {addrCnt_r[MEM_AW-1:1], ~addrCnt_r[0]};     // R5 R6
    assign commitNow = stopDet & (|pageDirty_r);                   // R8 R22
    assign nvBusy    = (nvTmr_r != '0);
    assign pageCommit = pageCommit_r;

    // open-drain data pin, only ever pulls low
    assign link.devSdaOut = 1'b0;
    assign link.devSdaOe  = sdaOe_r;

    ////////////////////////////////////////////////////////////////////////
    // byte protocol state machine
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r     <= ST_IDLE;
            bitCnt_r    <= 4'h0;
            shift_r     <= 8'h00;
            addrCnt_r   <= '0;
            pageBuf_r   <= '{default: 8'h00};
            pageDirty_r <= '0;
            sdaOe_r     <= 1'b0;
        end else if (startDet) begin
            // a new start always restarts address reception
            state_r     <= ST_ADDR;                                // R20
            // all ones: the start's own clock fall wraps it to bit zero
            bitCnt_r    <= '1;
            sdaOe_r     <= 1'b0;
            pageDirty_r <= '0;
        end else if (stopDet) begin
            state_r     <= ST_IDLE;
            bitCnt_r    <= 4'h0;
            sdaOe_r     <= 1'b0;
            pageDirty_r <= '0;
        end else if (sclRise) begin
            if (bitCnt_r < BIT_ACK && (state_r == ST_ADDR || state_r == ST_LOC
                                       || state_r == ST_WDAT)) begin
                shift_r <= {shift_r[6:0], sdaS};
            end else if (bitCnt_r == BIT_ACK && state_r == ST_RDAT && sdaS) begin
                state_r <= ST_IGN;                                 // R17
            end
        end else if (sclFall) begin
            case (state_r)
                ST_ADDR, ST_LOC, ST_WDAT: begin
                    if (bitCnt_r == BIT_LAST) begin
                        bitCnt_r <= BIT_ACK;
                        if (state_r != ST_ADDR) begin
                            sdaOe_r <= 1'b1;
                        end else if (addrMatch && !nvBusy) begin
                            sdaOe_r <= 1'b1;
                        end else begin
                            state_r <= ST_IGN;                     // R9 R20
                        end
                    end else if (bitCnt_r == BIT_ACK) begin
                        bitCnt_r <= 4'h0;
                        sdaOe_r  <= 1'b0;
                        case (state_r)
                            ST_ADDR: begin
                                if (shift_r[0] == RW_READ) begin
                                    state_r   <= ST_RDAT;          // R13
                                    shift_r   <= memRd;
                                    sdaOe_r   <= ~memRd[7];
                                    addrCnt_r <= addrCnt_r + 1'b1; // R21
                                end else begin
                                    state_r <= ST_LOC;
                                end
                            end
                            ST_LOC: begin
                                addrCnt_r <= shift_r;              // R1
                                state_r   <= ST_WDAT;
                            end
                            default: begin
                                pageBuf_r[addrCnt_r[0]]   <= shift_r;  // R3
                                pageDirty_r[addrCnt_r[0]] <= 1'b1;
                                addrCnt_r <= pageNext;             // R4 R6
                            end
                        endcase
                    end else begin
                        bitCnt_r <= bitCnt_r + 1'b1;
                    end
                end
                ST_RDAT: begin
                    if (bitCnt_r == BIT_LAST) begin
                        // release the line for the master's answer
                        bitCnt_r <= BIT_ACK;
                        sdaOe_r  <= 1'b0;
                    end else if (bitCnt_r == BIT_ACK) begin
                        // master acked: supply the following byte
                        bitCnt_r  <= 4'h0;
                        shift_r   <= memRd;                        // R16
                        sdaOe_r   <= ~memRd[7];
                        addrCnt_r <= addrCnt_r + 1'b1;             // R21
                    end else begin
                        bitCnt_r <= bitCnt_r + 1'b1;
                        shift_r  <= {shift_r[6:0], 1'b0};
                        sdaOe_r  <= ~shift_r[6];
                    end
                end
                default: begin
                    sdaOe_r <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nonvolatile page write and busy timer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            nvTmr_r      <= '0;
            pageCommit_r <= 1'b0;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_r[i] <= MEM_RESET;
            end
        end else begin
            pageCommit_r <= 1'b0;
            if (commitNow) begin
                // every byte of the page is rewritten, old value if untouched
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    mem_r[{addrCnt_r[MEM_AW-1:1], 1'(i)}] <=
                        pageDirty_r[i] ? pageBuf_r[i]
                                       : mem_r[{addrCnt_r[MEM_AW-1:1], 1'(i)}]; // R11 R12
                end
                nvTmr_r      <= NV_TMR_W'(NV_WRITE_CYCLES);        // R8
                pageCommit_r <= 1'b1;
            end else if (nvBusy) begin
                nvTmr_r <= nvTmr_r - 1'b1;
            end
        end
    end

endmodule: iep_dev

//--- design/iep_mst.sv
// bus master end: byte-level start, write, read and stop engine
`timescale 1ns/100ps
module iep_mst (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // link
    iep_link_if.mst               link,
    // command
    input  wire logic             cmdValid,
    input  iep_pkg::iep_cmd_e     cmdOp,
    input  wire logic [7:0]       cmdData,
    output logic                  cmdReady,
    // response
    output logic                  rspValid,
    output logic [7:0]            rspData,
    output logic                  rspAck
);
    import iep_pkg::*;

    typedef enum logic [1:0] {
        M_IDLE,
        M_START,
        M_BIT,
        M_STOP
    } iep_mst_e;

    iep_mst_e          state_r;
    iep_cmd_e          op_r;
    logic [1:0]        sdaSync_r;
    logic [QTR_W-1:0]  qtrCnt_r;
    logic [1:0]        phase_r;
    logic [3:0]        bitCnt_r;
    logic [7:0]        tx_r;
    logic [7:0]        rx_r;
    logic              scl_r;
    logic              sdaOe_r;
    logic              rspValid_r;
    logic [7:0]        rspData_r;
    logic              rspAck_r;
    logic              tick;
    logic [3:0]        nextBit;

    // level that the master puts on the line for a given bit
    function automatic logic drvBit(input iep_cmd_e op, input logic [7:0] tx, input logic [3:0] b);
        logic v;
        v = 1'b1;
        if (b == BIT_ACK) begin
            v = (op == CMD_READ_ACK) ? 1'b0 : 1'b1;   // R16 R17
        end else if (op == CMD_WRITE) begin
            v = tx[3'(3'd7 - b[2:0])];
        end
        return v;
    endfunction: drvBit

    assign tick      = (qtrCnt_r == QTR_W'(SCL_QTR_CYC - 1));
    assign nextBit   = bitCnt_r + 1'b1;
    assign cmdReady  = (state_r == M_IDLE);
    assign rspValid  = rspValid_r;
    assign rspData   = rspData_r;
    assign rspAck    = rspAck_r;
    assign link.scl       = scl_r;
    assign link.mstSdaOut = 1'b0;
    assign link.mstSdaOe  = sdaOe_r;

    ////////////////////////////////////////////////////////////////////////
    // data pin synchroniser
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sdaSync_r <= 2'h3;
        end else begin
            sdaSync_r <= {sdaSync_r[0], link.sda};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // quarter-period sequencer for start, bit and stop
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r    <= M_IDLE;
            op_r       <= CMD_STOP;
            qtrCnt_r   <= '0;
            phase_r    <= 2'h0;
            bitCnt_r   <= 4'h0;
            tx_r       <= 8'h00;
            rx_r       <= 8'h00;
            scl_r      <= 1'b1;
            sdaOe_r    <= 1'b0;
            rspValid_r <= 1'b0;
            rspData_r  <= 8'h00;
            rspAck_r   <= 1'b0;
        end else begin
            rspValid_r <= 1'b0;
            qtrCnt_r   <= tick ? '0 : qtrCnt_r + 1'b1;
            case (state_r)
                M_IDLE: begin
                    qtrCnt_r <= '0;
                    phase_r  <= 2'h0;
                    if (cmdValid) begin
                        op_r     <= cmdOp;
                        tx_r     <= cmdData;
                        bitCnt_r <= 4'h0;
                        case (cmdOp)
                            CMD_START: begin
                                state_r <= M_START;   // R15
                                sdaOe_r <= 1'b0;
                            end
                            CMD_STOP: begin
                                state_r <= M_STOP;    // R14 R17
                                sdaOe_r <= 1'b1;
                            end
                            default: begin
                                state_r <= M_BIT;
                                sdaOe_r <= ~drvBit(cmdOp, cmdData, 4'h0);
                            end
                        endcase
                    end
                end
                M_START: begin
                    if (tick) begin
                        phase_r <= phase_r + 1'b1;
                        case (phase_r)
                            2'h0: scl_r   <= 1'b1;
                            2'h1: sdaOe_r <= 1'b1;
                            2'h2: scl_r   <= 1'b0;
                            default: state_r <= M_IDLE;
                        endcase
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        phase_r <= phase_r + 1'b1;
                        case (phase_r)
                            2'h0: scl_r   <= 1'b1;
                            2'h1: sdaOe_r <= 1'b0;
                            2'h2: scl_r   <= 1'b1;
                            default: state_r <= M_IDLE;
                        endcase
                    end
                end
                M_BIT: begin
                    if (tick) begin
                        phase_r <= phase_r + 1'b1;
                        case (phase_r)
                            2'h0: scl_r <= 1'b1;
                            2'h1: scl_r <= 1'b1;
                            2'h2: begin
                                scl_r <= 1'b0;
                                if (bitCnt_r < BIT_ACK) begin
                                    rx_r <= {rx_r[6:0], sdaSync_r[1]};
                                end else if (op_r == CMD_WRITE) begin
                                    rspAck_r <= ~sdaSync_r[1];   // R2 R10
                                end else begin
                                    rspAck_r <= (op_r == CMD_READ_ACK);
                                end
                            end
                            default: begin
                                if (bitCnt_r == BIT_ACK) begin
                                    state_r    <= M_IDLE;
                                    sdaOe_r    <= 1'b0;
                                    rspValid_r <= 1'b1;
                                    rspData_r  <= (op_r == CMD_WRITE) ? tx_r : rx_r;
                                end else begin
                                    bitCnt_r <= nextBit;
                                    sdaOe_r  <= ~drvBit(op_r, tx_r, nextBit);
                                end
                            end
                        endcase
                    end
                end
                default: state_r <= M_IDLE;
            endcase
        end
    end

endmodule: iep_mst

//--- dv/iep_link_props.sv
// concurrent checks on the two-wire link and the device status outputs
`timescale 1ns/100ps
module iep_link_props #(
    parameter int NVC = 150
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // link
    input wire logic scl,
    input wire logic sda,
    input wire logic mstSdaOut,
    input wire logic mstSdaOe,
    input wire logic devSdaOut,
    input wire logic devSdaOe,
    // status
    input wire logic nvBusy,
    input wire logic pageCommit
);
    logic [19:0] busyCnt_r;
    logic [7:0]  stopSeen_r;
    logic        sclD_r;
    logic        sdaD_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////
    // previous link levels for stop detection
    always_ff @(posedge core_clk) begin
        sclD_r <= scl;
        sdaD_r <= sda;
    end

    // recent stop conditions, eight cycles deep
    always_ff @(posedge core_clk) begin
        if (srst) begin
            stopSeen_r <= 8'h00;
        end else begin
            stopSeen_r <= {stopSeen_r[6:0], sclD_r & scl & ~sdaD_r & sda};
        end
    end

    // length of the current busy window
    always_ff @(posedge core_clk) begin
        if (srst || !nvBusy) begin
            busyCnt_r <= 20'h00000;
        end else begin
            busyCnt_r <= busyCnt_r + 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_open_drain_low: assert property (!devSdaOut && !mstSdaOut)
        else $error("data line driven high");
    a_reset_leaves_idle: assert property ($fell(srst) |-> scl && !devSdaOe && !mstSdaOe)
        else $error("link not idle after reset");
    a_commit_sets_busy: assert property (pageCommit |-> ##[0:2] nvBusy)
        else $error("page commit without busy window");
    a_busy_from_commit: assert property ($rose(nvBusy) |-> pageCommit || $past(pageCommit))
        else $error("busy window without page commit");
    a_busy_len_bound: assert property (busyCnt_r <= 20'(NVC))
        else $error("busy window too long");
    a_busy_len_exact: assert property ($fell(nvBusy) |-> busyCnt_r == 20'(NVC))
        else $error("busy window wrong length");
    a_commit_after_stop: assert property (pageCommit |-> |stopSeen_r)
        else $error("page commit not after stop");
    a_busy_no_ack: assert property (nvBusy |-> !devSdaOe)
        else $error("device drives data while busy");
    a_release_on_stop: assert property (stopSeen_r[0] |-> !devSdaOe [*8])
        else $error("device drives data after stop");
    a_drive_scl_low: assert property ($changed(devSdaOe) |-> !scl)
        else $error("device changed data while clock high");

    cover property (pageCommit);
    cover property ($fell(nvBusy));
    cover property (scl && devSdaOe);
endmodule: iep_link_props

//--- dv/tb_i2c_eeprom_page_access.sv
// self-checking bench: master end drives device end across the two-wire link
`timescale 1ns/100ps
module tb_i2c_eeprom_page_access;
    import iep_pkg::*;
    localparam int NVC = 150;
    logic       core_clk   = 1'b0;
    logic       srst       = 1'b1;
    logic       cmdValid   = 1'b0;
    iep_cmd_e   cmdOp      = CMD_START;
    logic [7:0] cmdData    = 8'h00;
    logic [2:0] sel;
    logic       cmdReady;
    logic       rspValid;
    logic       rspAck;
    logic       nvBusy;
    logic       pageCommit;
    logic [7:0] rspData;
    logic [8:0] expQ[$];
    logic [7:0] shadow[256];
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         seed       = 32737;

    iep_link_if link();
    iep_mst iep_mst_inst (.core_clk(core_clk), .srst(srst), .link(link), .cmdValid(cmdValid),
        .cmdOp(cmdOp), .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
        .rspData(rspData), .rspAck(rspAck));
    iep_dev #(.NV_WRITE_CYCLES(NVC)) iep_dev_inst (.core_clk(core_clk), .srst(srst), .link(link),
        .addrSelectBit0(sel[0]), .addrSelectBit1(sel[1]), .addrSelectBit2(sel[2]),
        .nvBusy(nvBusy), .pageCommit(pageCommit));
    iep_link_props #(.NVC(NVC)) iep_link_props_inst (.core_clk(core_clk), .srst(srst),
        .scl(link.scl), .sda(link.sda), .mstSdaOut(link.mstSdaOut), .mstSdaOe(link.mstSdaOe),
        .devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe), .nvBusy(nvBusy), .pageCommit(pageCommit));

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string name, logic [8:0] exp, logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask: chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask: print_verdict

    // one master command, held until taken
    task automatic cmd(iep_cmd_e op, logic [7:0] d);
        int i;
        @(posedge core_clk);
        #1;
        cmdValid = 1'b1;
        cmdOp = op;
        cmdData = d;
        for (i = 0; i < 400 && cmdReady !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        if (i == 400) begin
            n_mismatch++;
            print_verdict();
        end
        @(posedge core_clk);
        #1;
        cmdValid = 1'b0;
    endtask: cmd

    function automatic logic [7:0] adrb(logic rw);
        return {DEV_ADDR_HI, sel, rw};
    endfunction: adrb

    // byte out, expecting the given acknowledge
    task automatic wb(logic [7:0] d, logic ack);
        expQ.push_back({d, ack});
        cmd(CMD_WRITE, d);
    endtask: wb

    // byte in, master asks for more when more is set
    task automatic rb(logic [7:0] exp, logic more);
        expQ.push_back({exp, more});
        cmd(more ? CMD_READ_ACK : CMD_READ_NACK, 8'h00);
    endtask: rb

    // write n bytes at loc, then poll through the busy window
    task automatic wpage(logic [7:0] loc, int n);
        logic [7:0] d;
        int         k;
        cmd(CMD_START, 8'h00);
        wb(adrb(1'b0), 1'b1);
        wb(loc, 1'b1);
        for (k = 0; k < n; k++) begin
            d = 8'($random(seed));
            shadow[{loc[7:1], loc[0] ^ k[0]}] = d;
            wb(d, 1'b1);
        end
        cmd(CMD_STOP, 8'h00);
        repeat (10) @(posedge core_clk);
        #1;
        chk("nvBusy", {8'h00, n > 0}, {8'h00, nvBusy});
        if (n > 0) begin
            cmd(CMD_START, 8'h00);
            wb(adrb(1'b0), 1'b0);
            cmd(CMD_STOP, 8'h00);
            for (k = 0; k < 300 && nvBusy !== 1'b0; k++) begin
                @(posedge core_clk);
            end
            chk("busy end", 9'h000, {8'h00, nvBusy});
            cmd(CMD_START, 8'h00);
            wb(adrb(1'b0), 1'b1);
            cmd(CMD_STOP, 8'h00);
        end
    endtask: wpage

    // read n bytes, from loc after a dummy write or from the counter
    task automatic rdseq(logic [7:0] loc, int n, logic setLoc);
        int k;
        cmd(CMD_START, 8'h00);
        if (setLoc) begin
            wb(adrb(1'b0), 1'b1);
            wb(loc, 1'b1);
            cmd(CMD_START, 8'h00);
        end
        wb(adrb(1'b1), 1'b1);
        for (k = 0; k < n; k++) begin
            rb(shadow[8'(loc + k)], k < n - 1);
        end
        cmd(CMD_STOP, 8'h00);
    endtask: rdseq

    ////////////////////////////////////////////////////////////////////////
    // result watcher: oldest note against each finished byte, sampled mid-cycle
    always @(negedge core_clk) begin
        if (rspValid === 1'b1) begin
            if (expQ.size() == 0) begin
                chk("unexpected byte", 9'h000, {rspData, rspAck});
            end else begin
                chk("byte and ack", expQ.pop_front(), {rspData, rspAck});
            end
        end
    end

    // main sequence
    initial begin
        sel = 3'($random(seed));
        for (int k = 0; k < 256; k++) begin
            shadow[k] = MEM_RESET;
        end
        repeat (12) @(posedge core_clk);
        #1;
        srst = 1'b0;
        repeat (6) @(posedge core_clk);
        wpage(8'h04, 2);
        wpage(8'h07, 1);
        wpage(8'h08, 3);
        wpage(8'h0e, 4);
        wpage(8'hfe, 1);
        rdseq(8'h04, 6, 1'b1);
        rdseq(8'h0e, 2, 1'b1);
        wpage(8'hff, 0);
        rdseq(8'hff, 2, 1'b0);
        cmd(CMD_START, 8'h00);
        wb({DEV_ADDR_HI, ~sel, 1'b0}, 1'b0);
        wb(8'h33, 1'b0);
        cmd(CMD_STOP, 8'h00);
        repeat (10) @(posedge core_clk);
        #1;
        chk("nvBusy", 9'h000, {8'h00, nvBusy});
        rdseq(8'hfe, 2, 1'b1);
        repeat (20) @(posedge core_clk);
        chk("queue left", 9'h000, 9'(expQ.size()));
        print_verdict();
    end
endmodule: tb_i2c_eeprom_page_access
